//--- hw/kli_pkg.sv
`default_nettype none
package kli_pkg;
   // special function register addresses
   localparam logic [7:0] KLI_ADDR_AUX = 8'h90;
   localparam logic [7:0] KLI_ADDR_CTRL = 8'ha3;
   localparam logic [7:0] KLI_ADDR_STAT = 8'ha4;
   // reset values
   localparam logic [7:0] KLI_AUX_RST = 8'hff;
   localparam logic [7:0] KLI_CTRL_RST = 8'h0f;
   localparam logic [7:0] KLI_STAT_RST = 8'h00;
   // field positions
   localparam int KLI_CTRL_MASK_BIT = 0;
   localparam int KLI_CTRL_LEVEL_BIT = 4;
   localparam int KLI_STAT_FLAG_BIT = 0;
   localparam int KLI_STAT_WAKE_BIT = 7;
   localparam int KLI_AUX_KEY_BIT = 0;
   localparam int KLI_AUX_DAC_LSB = 1;
   localparam int KLI_AUX_DAC_MSB = 5;
   localparam int KLI_AUX_TWI_LSB = 6;
   // writable bits of the auxiliary register (key input bit is read-only)
   localparam logic [7:0] KLI_AUX_WMASK = 8'hfe;
endpackage
`default_nettype wire

//--- hw/kli_keypad.sv
`default_nettype none
module kli_keypad (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // special function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // pins and core hooks
   input wire logic keypad_input_line,
   input wire logic keypad_irq_global_enable,
   input wire logic [1:0] twi_line_in,
   output logic keypad_irq,
   output logic keypad_wake,
   output logic [4:0] dac_ctrl_out
);
   import kli_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] aux_q, aux_d;
   logic flag_q, flag_d;
   logic wake_en_q, wake_en_d;
   logic [7:0] rdata_q, rdata_d;

   // one address compare shared by every register select
   function automatic logic kli_addr_hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   wire logic sel_ctrl = kli_addr_hit(sfr_addr, KLI_ADDR_CTRL);
   wire logic sel_stat = kli_addr_hit(sfr_addr, KLI_ADDR_STAT);
   wire logic sel_aux = kli_addr_hit(sfr_addr, KLI_ADDR_AUX);
   // write data fields, named so the checks can look back at them
   wire logic [4:0] wdata_dac = sfr_wdata[KLI_AUX_DAC_MSB:KLI_AUX_DAC_LSB];
   wire logic wdata_wake = sfr_wdata[KLI_STAT_WAKE_BIT];
   wire logic wdata_mask = sfr_wdata[KLI_CTRL_MASK_BIT];

   wire logic wr_ctrl = sfr_wr && sel_ctrl;
   wire logic wr_stat = sfr_wr && sel_stat;
   wire logic wr_aux = sfr_wr && sel_aux;
   wire logic rd_stat = sfr_rd && sel_stat;

   wire logic level_sel = ctrl_q[KLI_CTRL_LEVEL_BIT];
   wire logic flag_mask = ctrl_q[KLI_CTRL_MASK_BIT];
   // level compare; xnor gives a match for either polarity
   wire logic key_match = ~(keypad_input_line ^ level_sel);

   // set wins over the read-clear so a press during the read survives
   assign flag_d = key_match ? 1'b1 : (rd_stat ? 1'b0 : flag_q);
   assign wake_en_d = wr_stat ? wdata_wake : wake_en_q;
   // reserved control bits are stored as written; software keeps them fixed
   assign ctrl_d = wr_ctrl ? sfr_wdata : ctrl_q;
   assign aux_d = wr_aux ? (sfr_wdata & KLI_AUX_WMASK) | (aux_q & ~KLI_AUX_WMASK) : aux_q;

   wire logic [7:0] stat_view = {wake_en_q, 6'h00, flag_q};
   // twi bits show the live lines, key bit the live input
   wire logic [7:0] aux_view = {twi_line_in, aux_q[KLI_AUX_DAC_MSB:KLI_AUX_DAC_LSB],
                                keypad_input_line};

   always_comb begin
      rdata_d = 8'h00;
      if (sfr_rd) begin
         if (sel_ctrl) rdata_d = ctrl_q;
         else if (sel_stat) rdata_d = stat_view;
         else if (sel_aux) rdata_d = aux_view;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_q <= KLI_CTRL_RST;
         flag_q <= KLI_STAT_RST[KLI_STAT_FLAG_BIT];
         wake_en_q <= KLI_STAT_RST[KLI_STAT_WAKE_BIT];
         aux_q <= KLI_AUX_RST;
         rdata_q <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         flag_q <= flag_d;
         wake_en_q <= wake_en_d;
         aux_q <= aux_d;
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata = rdata_q;
   assign dac_ctrl_out = aux_q[KLI_AUX_DAC_MSB:KLI_AUX_DAC_LSB];
   assign keypad_irq = flag_q && !flag_mask && keypad_irq_global_enable;
   // raw compare, not the flag, so wake works with clocks stopped
   assign keypad_wake = wake_en_q && key_match;

   ////////////////////////////////////////////////////////////////////////
   sequence s_stat_read;
      sfr_rd && sel_stat && !key_match;
   endsequence

   sequence s_stat_access;
      sfr_rd && sel_stat;
   endsequence

   sequence s_ctrl_read;
      sfr_rd && sel_ctrl;
   endsequence

   sequence s_aux_read;
      sfr_rd && sel_aux;
   endsequence

   sequence s_fresh_flag;
      $rose(flag_q) && !flag_mask && keypad_irq_global_enable;
   endsequence

   a_level_sets_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      key_match |=> flag_q)
      else $error("flag not set on active level");
   a_read_clears_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_stat_read |=> !flag_q)
      else $error("status read did not clear flag");
   a_flag_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_q && !rd_stat |=> flag_q)
      else $error("flag lost without read");
   a_stat_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_rd && sel_stat |=> sfr_rdata[6:1] == 6'h00)
      else $error("status reserved bits not zero");
   a_ctrl_reset_value: assert property (@(posedge clk_sys)
      !rst_n |=> ctrl_q == KLI_CTRL_RST)
      else $error("control reset value wrong");
   a_stat_reset_value: assert property (@(posedge clk_sys)
      !rst_n |=> !flag_q && !wake_en_q)
      else $error("status reset value wrong");
   a_aux_key_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_rd && sel_aux |=> sfr_rdata[0] == $past(keypad_input_line))
      else $error("aux key bit wrong");
   a_irq_gating: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_fresh_flag |-> keypad_irq)
      else $error("new unmasked flag gave no irq");
   a_mask_blocks_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl && wdata_mask |=> !keypad_irq)
      else $error("masked flag raised irq");
   a_wake_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wake_en_q |-> !keypad_wake)
      else $error("wake without enable");

   // detection against the raw pin, independent of the compare wire except a_flag_needs_match
   a_level_high_detect: assert property (@(posedge clk_sys) disable iff (!rst_n)
      level_sel && keypad_input_line |=> flag_q)
      else $error("high level not detected");
   a_level_low_detect: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !level_sel && !keypad_input_line |=> flag_q)
      else $error("low level not detected");
   a_mismatch_stays_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (keypad_input_line != level_sel) && !flag_q |=> !flag_q)
      else $error("flag set on wrong level");
   a_flag_needs_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(flag_q) |-> $past(key_match))
      else $error("flag rose without match");
   a_ctrl_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_ctrl |=> ctrl_q == $past(sfr_wdata))
      else $error("control write lost");
   a_ctrl_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_ctrl |=> $stable(ctrl_q))
      else $error("control changed without write");

   // register views
   a_read_shows_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_stat_access |=> sfr_rdata[KLI_STAT_FLAG_BIT] == $past(flag_q))
      else $error("status read lost flag");
   a_read_shows_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_stat_access |=> sfr_rdata[KLI_STAT_WAKE_BIT] == $past(wake_en_q))
      else $error("status read lost wake enable");
   a_stat_write_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_stat |=> wake_en_q == $past(wdata_wake))
      else $error("wake enable write lost");
   a_ctrl_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_ctrl_read |=> sfr_rdata == $past(ctrl_q))
      else $error("control readback wrong");
   a_aux_twi_mirror: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_aux_read |=> sfr_rdata[7:KLI_AUX_TWI_LSB] == $past(twi_line_in))
      else $error("aux twi bits wrong");
   a_aux_dac_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_aux |=> dac_ctrl_out == $past(wdata_dac))
      else $error("dac lines not written");
   a_dac_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !wr_aux |=> $stable(dac_ctrl_out))
      else $error("dac lines changed without write");
   a_aux_reset_value: assert property (@(posedge clk_sys)
      !rst_n |=> dac_ctrl_out == KLI_AUX_RST[KLI_AUX_DAC_MSB:KLI_AUX_DAC_LSB])
      else $error("dac reset value wrong");

   // request outputs
   a_irq_needs_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      keypad_irq |-> flag_q)
      else $error("irq without flag");
   a_irq_needs_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
      keypad_irq |-> keypad_irq_global_enable)
      else $error("irq without global enable");
   a_unmask_raises: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_q && !flag_mask && keypad_irq_global_enable |-> keypad_irq)
      else $error("unmasked flag gave no irq");
   a_masked_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      flag_mask |-> !keypad_irq)
      else $error("irq while masked");
   a_wake_on_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wake_en_q && (keypad_input_line == level_sel) |-> keypad_wake)
      else $error("no wake on enabled match");
   a_wake_needs_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
      keypad_wake |-> keypad_input_line == level_sel)
      else $error("wake without level match");
endmodule
`default_nettype wire

//--- sim/kli_switch_model.sv
`default_nettype none
module kli_switch_model (
   // user action
   input wire logic pressed,
   // keypad pin
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;
   // open contact: pull-up holds the pin high
   assign line = pressed ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

//--- sim/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import kli_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] a = 8'h00, wd = 8'h00, rdata;
   logic wr = 1'b0, rd = 1'b0, en = 1'b1, pressed = 1'b0, key, irq, wake;
   logic [1:0] twi = 2'b11;
   logic [4:0] dac;
   int fail_count = 0;
   int checks = 0;
   always #2 clk_sys = ~clk_sys;
   kli_switch_model u_kli_switch_model (.pressed(pressed), .line(key));
   kli_keypad u_kli_keypad (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(a), .sfr_wr(wr),
      .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdata), .keypad_input_line(key),
      .keypad_irq_global_enable(en), .twi_line_in(twi), .keypad_irq(irq),
      .keypad_wake(wake), .dac_ctrl_out(dac));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // strobes rise one negedge after the last fall, never twice in one step
   task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk_sys);
      a = ad;
      wd = d;
      wr = 1'b1;
      @(negedge clk_sys) wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] ad, input logic [7:0] e);
      @(negedge clk_sys);
      a = ad;
      rd = 1'b1;
      @(negedge clk_sys) rd = 1'b0;
      chk("rdata", e, rdata);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      rd_reg(KLI_ADDR_CTRL, KLI_CTRL_RST);
      rd_reg(KLI_ADDR_STAT, KLI_STAT_RST);
      rd_reg(KLI_ADDR_AUX, KLI_AUX_RST);
      chk("dac", {3'h0, KLI_AUX_RST[KLI_AUX_DAC_MSB:KLI_AUX_DAC_LSB]}, {3'h0, dac});
      rd_reg(8'h55, 8'h00);
      wr_reg(KLI_ADDR_CTRL, 8'h0e);
      pressed = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("irq", 8'h01, {7'h00, irq});
      chk("wake", 8'h00, {7'h00, wake});
      en = 1'b0;
      @(negedge clk_sys);
      chk("irq", 8'h00, {7'h00, irq});
      en = 1'b1;
      pressed = 1'b0;
      rd_reg(KLI_ADDR_STAT, 8'h01);
      rd_reg(KLI_ADDR_STAT, 8'h00);
      chk("irq", 8'h00, {7'h00, irq});
      wr_reg(KLI_ADDR_CTRL, 8'h1f);
      rd_reg(KLI_ADDR_STAT, 8'h01);
      chk("irq", 8'h00, {7'h00, irq});
      // reserved status bits written high must still read low
      wr_reg(KLI_ADDR_STAT, 8'hfe);
      rd_reg(KLI_ADDR_STAT, 8'h81);
      chk("wake", 8'h01, {7'h00, wake});
      pressed = 1'b1;
      twi = 2'b10;
      wr_reg(KLI_ADDR_AUX, 8'h54);
      chk("wake", 8'h00, {7'h00, wake});
      chk("dac", 8'h0a, {3'h0, dac});
      rd_reg(KLI_ADDR_AUX, 8'h94);
      // reset in mid-run must override written control, wake and dac state
      pressed = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      chk("dac", {3'h0, KLI_AUX_RST[KLI_AUX_DAC_MSB:KLI_AUX_DAC_LSB]}, {3'h0, dac});
      rd_reg(KLI_ADDR_CTRL, KLI_CTRL_RST);
      rd_reg(KLI_ADDR_STAT, KLI_STAT_RST);
      give_verdict();
   end
   // tests need about 40 cycles; generous margin for a hung strobe
   initial begin
      #20000;
      fail_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
